// file: dv/quad_wiper_assertions.sv
`timescale 1ns/10ps
module quad_wiper_assertions (
  input wire core_clk_i,
  input wire rst_i,
  input wire cs_n_i,
  input wire preset_strobe_n_i,
  input wire sdo_oe_o,
  input wire ready_oe_o,
  input wire latched_output_one_o,
  input wire latched_output_two_o,
  input wire [255:0] tap_select_o,
  input wire [23:0] wiper_register_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  wire [5:0] w0 = wiper_register_o[5:0];
  tap_match_a: assert property ($stable(w0) |->
    tap_select_o[w0]) else $error("tap not at wiper code");
  tap_onehot_a: assert property ($onehot(tap_select_o[63:0]) &&
    $onehot(tap_select_o[255:192])) else $error("tap not one-hot");
  exec_on_rise_a: assert property (
    (!cs_n_i && preset_strobe_n_i)[*8] |->
    $stable(wiper_register_o)) else $error("wiper moved in frame");
  latched_hold_a: assert property (cs_n_i[*8] |->
    $stable({latched_output_one_o, latched_output_two_o}))
    else $error("latched output moved while idle");
  sdo_idle_a: assert property (cs_n_i[*6] |-> !sdo_oe_o)
    else $error("serial out driven while deselected");
  ready_pulse_a: assert property (ready_oe_o |=> !ready_oe_o[*8])
    else $error("ready pulse too long");
  preset_mid_a: assert property (!preset_strobe_n_i[*6] |->
    wiper_register_o == 24'h820820) else $error("preset not midscale");
  boot_mid_a: assert property ($fell(rst_i) |-> ##[1:4]
    wiper_register_o == 24'h820820) else $error("no boot reload");
endmodule // quad_wiper_assertions
bind quad_wiper_command_logic quad_wiper_assertions u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i),
  .preset_strobe_n_i(preset_strobe_n_i), .sdo_oe_o(sdo_oe_o),
  .ready_oe_o(ready_oe_o), .latched_output_one_o(latched_output_one_o),
  .latched_output_two_o(latched_output_two_o),
  .tap_select_o(tap_select_o), .wiper_register_o(wiper_register_o));

// file: dv/quad_wiper_command_logic_tb.sv
`timescale 1ns/10ps
module quad_wiper_command_logic_tb;
  reg core_clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg preset_n = 1'b1;
  wire sclk, cs_n, sdi, sdo_o, sdo_oe_o, ready_n_o, ready_oe_o, lo1, lo2, rds;
  wire [255:0] taps;
  wire [23:0] wreg;
  integer err_total = 0, n_tests = 0, i, k, n, wm[0:3], nv[0:15];
  reg [15:0] rd, last, w;
  localparam [175:0] DIRS = {16'hB000, 16'h60A5, 16'hC0A5, 16'hB13F,
    16'hE1FF, 16'hB220, 16'hC200, 16'hD000, 16'h5000, 16'h7000, 16'hF000};
  always #4 core_clk_i = ~core_clk_i;
  quad_wiper_command_logic #(.STORE_CYCLES(100)) u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .clk_en_i(1'b1),
    .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .preset_strobe_n_i(preset_n),
    .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o), .ready_n_o(ready_n_o),
    .ready_oe_o(ready_oe_o), .latched_output_one_o(lo1),
    .latched_output_two_o(lo2), .read_state_o(rds),
    .tap_select_o(taps), .wiper_register_o(wreg));
  spi_host_model u_host (.sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi),
    .sdo_i(sdo_oe_o ? 1'b0 : 1'b1));
  ////////////////////////////////////////////////////////////////////
  function integer nxt(input [3:0] c, input integer v, input [7:0] d);
    case (c)
      4'h4, 4'h5: nxt = v / 2;
      4'h6, 4'h7: nxt = (v == 0) ? 0 : v - 1;
      4'hC, 4'hD:
        nxt = (v == 0) ? 1 : (v >= 32) ? 63 : v * 2;
      4'hE, 4'hF: nxt = (v == 63) ? 63 : v + 1;
      4'hB: nxt = d[5:0];
      default: nxt = v;
    endcase
  endfunction
  task check(input [63:0] s, input [63:0] e, input [63:0] nm);
    begin
      n_tests = n_tests + 1;
      if (s !== e) begin
        err_total = err_total + 1;
        $display("mismatch %0s exp %0h seen %0h", nm, e, s);
      end
    end
  endtask
  task chk;
    begin
      check(wreg, {wm[3][5:0], wm[2][5:0], wm[1][5:0], wm[0][5:0]},
        "wiper");
      for (k = 0; k < 4; k = k + 1)
        check(taps[64*k +: 64], 64'h1 << wm[k], "tap");
    end
  endtask
  task upd(input [15:0] x);
    begin
      for (k = 0; k < 4; k = k + 1)
        if ((x[12] && x[15:12] != 4'hB) || k == x[9:8])
          wm[k] = nxt(x[15:12], wm[k], x[7:0]);
      case (x[15:12])
        4'h1: wm[x[9:8]] = nv[x[9:8]] % 64;
        4'h2: nv[x[11:8]] = wm[x[9:8]];
        4'h3: nv[x[11:8]] = x[7:0];
        4'h8: for (k = 0; k < 4; k = k + 1) wm[k] = nv[k] % 64;
        default: ;
      endcase
    end
  endtask
  task cmd(input [15:0] x);
    begin
      u_host.xfer(x, rd);
      upd(x);
      if (x[15:13] == 3'b001) begin
        n = 0;
        while (ready_oe_o !== 1'b1 && n < 300) begin
          @(negedge core_clk_i);
          n = n + 1;
        end
        check(n > 40 && n < 300, 1'b1, "ready");
        check(ready_n_o, 1'b0, "readyn");
      end
      repeat (4) @(negedge core_clk_i);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    #600000;
    err_total = err_total + 1;
    summarize;
  end
  initial begin
    rd = $urandom(32'hE43C);
    for (k = 0; k < 16; k = k + 1) nv[k] = (k < 4) ? 32 : (k == 4) ? 3 : 0;
    for (k = 0; k < 4; k = k + 1) wm[k] = 32;
    repeat (5) @(negedge core_clk_i);
    rst_i = 1'b0;
    repeat (8) @(negedge core_clk_i);
    chk;
    check({lo1, lo2}, 2'b11, "latch");
    for (i = 0; i < 11; i = i + 1) begin
      cmd(DIRS[175 - 16 * i -: 16]);
      chk;
    end
    u_host.pulse;
    upd(16'hF000);
    chk;
    last = 16'hF000;
    for (i = 0; i < 40; i = i + 1) begin
      w = $urandom;
      w[11:10] = 2'b00;
      if (w[15:12] < 4'h4 || (w[15:12] > 4'h7 && w[15:12] < 4'hB))
        w[15:12] = 4'hB;
      cmd(w);
      chk;
      check(rd, last, "echo");
      last = w;
    end
    cmd(16'hB215);
    cmd(16'h2200);
    cmd(16'hB201);
    cmd(16'h1200);
    chk;
    check(rds, 1'b1, "rdstate");
    cmd(16'h0000);
    check(rds, 1'b0, "rdstate");
    cmd(16'hA100);
    cmd(16'h0000);
    check(rd[7:0], wm[1], "rdwiper");
    cmd(16'h37C3);
    cmd(16'h9700);
    cmd(16'h0000);
    check(rd[7:0], nv[7], "user");
    cmd(16'h3401);
    cmd(16'h8000);
    chk;
    check({lo1, lo2}, 2'b10, "latch");
    cmd(16'hB03F);
    preset_n = 1'b0;
    repeat (10) @(negedge core_clk_i);
    check(wreg, 24'h820820, "preset");
    preset_n = 1'b1;
    wm[0] = nv[0];
    repeat (10) @(negedge core_clk_i);
    chk;
    check({lo1, lo2}, 2'b10, "latch");
    summarize;
  end
endmodule // quad_wiper_command_logic_tb

// file: dv/spi_host_model.sv
`timescale 1ns/10ps
module spi_host_model (
  output reg sclk_o,
  output reg cs_n_o,
  output reg sdi_o,
  input wire sdo_i
);
  integer i;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b0;
  end
  // clock idles low; data line flips after a frame so no stale bit lingers
  task xfer(input [15:0] w, output [15:0] r);
    begin
      cs_n_o = 1'b0;
      for (i = 15; i >= 0; i = i - 1) begin
        sdi_o = w[i];
        #62.5 sclk_o = 1'b1;
        r[i] = sdo_i;
        #62.5 sclk_o = 1'b0;
      end
      sdi_o = ~w[0];
      #125 cs_n_o = 1'b1;
      #250;
    end
  endtask
  task pulse;
    begin
      cs_n_o = 1'b0;
      #125 cs_n_o = 1'b1;
      #250;
    end
  endtask
endmodule // spi_host_model

// file: rtl/quad_wiper_command_logic.v
// Operation
// - word: command, address, data byte
// - serial out replays previous sixteen bits
// - execute only when select rises
// - command 3 writes one stored byte
// - step and shift ignore data byte
// - 14 steps one up, 15 all
// - 6 steps one down, 7 all
// - 12 and 13 double wiper code
// - left shift of zero gives one
// - left shift at midscale saturates full
// - 4 and 5 halve wiper code
// - restore one holds read state until nop
// - latched outputs reload on 1, 8, power
// - wipers reload on power, 1, 8, preset
// - latched outputs default high, held
// - eleven user bytes, store 3, read 9
// - code selects one of 64 taps
// - power-on preset reloads wiper registers
// - sixteen command codes decoded
// - msb first; bare select pulse repeats
// - store locks shifter, ready pulses low
// - preset low midscale, rise reloads
`timescale 1ns/10ps
`include "quad_wiper_defines.vh"
module quad_wiper_command_logic #(
  parameter STORE_CYCLES = `STORE_CYCLES
) (
  input wire core_clk_i,
  input wire rst_i,
  input wire clk_en_i,
  input wire sclk_i,
  input wire cs_n_i,
  input wire sdi_i,
  input wire preset_strobe_n_i,
  output reg sdo_o,
  output reg sdo_oe_o,
  output reg ready_n_o,
  output reg ready_oe_o,
  output reg latched_output_one_o,
  output reg latched_output_two_o,
  output reg read_state_o,
  output reg [255:0] tap_select_o,
  output reg [23:0] wiper_register_o
);
////////////////////////////////////////////////////////////////////////////////
reg [1:0] sclk_sync_reg;
reg [1:0] cs_sync_reg;
reg [1:0] sdi_sync_reg;
reg [1:0] preset_sync_reg;
reg sclk_d_reg;
reg cs_d_reg;
reg preset_d_reg;

// serial side state
reg [15:0] shift_reg;
reg [15:0] last_word_reg;
reg [15:0] readback_reg;
reg readback_pend_reg;
reg [4:0] bit_cnt_reg;
reg have_word_reg;

// storage and timers
reg [5:0] wiper_reg [0:3];
reg [7:0] nvs_reg [0:15];
reg [31:0] store_cnt_reg;
reg store_busy_reg;
reg boot_reg;

// only the second stage of each synchroniser is read
wire sclk_s = sclk_sync_reg[1];
wire cs_s = cs_sync_reg[1];
wire preset_s = preset_sync_reg[1];
wire sclk_rise = sclk_s & ~sclk_d_reg;
wire sclk_fall = ~sclk_s & sclk_d_reg;
wire cs_rise = cs_s & ~cs_d_reg;
wire preset_rise = preset_s & ~preset_d_reg;

// a bare select pulse reuses the last word
wire [15:0] word = (bit_cnt_reg == 5'h00) ? last_word_reg : shift_reg;
// lengths not a multiple of 16 are dropped; a 32-bit frame runs on its last sixteen bits
wire frame_ok = (bit_cnt_reg[3:0] == 4'h0) &&
                (have_word_reg ||
                 bit_cnt_reg != 5'h00);
wire [3:0] cmd = word[`CMD_MSB:`CMD_LSB];
wire [3:0] adr = word[`ADR_MSB:`ADR_LSB];
wire [7:0] dat = word[7:0];
wire exec = cs_rise & frame_ok & ~store_busy_reg;
////////////////////////////////////////////////////////////////////////////////
// per-channel wiper arithmetic
// saturating: codes never wrap past either end
function [5:0] wiper_op;
  input [3:0] c;
  input [5:0] w;
  begin
    case (c)
      `CMD_SHR_ONE, `CMD_SHR_ALL: wiper_op = {1'b0, w[5:1]};
      `CMD_DEC_ONE, `CMD_DEC_ALL:
        wiper_op = (w == 6'h00) ? w : w - 6'h01;
      `CMD_SHL_ONE, `CMD_SHL_ALL: begin
        if (w == 6'h00) wiper_op = 6'h01;
        else if (w >= `WIPER_MID) wiper_op = `WIPER_FULL;
        else wiper_op = {w[4:0], 1'b0};
      end
      `CMD_INC_ONE, `CMD_INC_ALL:
        wiper_op = (w == `WIPER_FULL) ? w : w + 6'h01;
      default: wiper_op = w;
    endcase
  end
endfunction
////////////////////////////////////////////////////////////////////////////////
always @(posedge core_clk_i) begin
  if (rst_i) begin
    sclk_sync_reg <= 2'h0;
    cs_sync_reg <= 2'h3;
    sdi_sync_reg <= 2'h0;
    // reset values match the idle pin levels: no false edge after reset
    preset_sync_reg <= 2'h3;
    sclk_d_reg <= 1'b0;
    cs_d_reg <= 1'b1;
    preset_d_reg <= 1'b1;
  end else if (clk_en_i) begin
    // three cycles pass before any pin change is acted upon
    sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
    cs_sync_reg <= {cs_sync_reg[0], cs_n_i};
    sdi_sync_reg <= {sdi_sync_reg[0], sdi_i};
    preset_sync_reg <= {preset_sync_reg[0], preset_strobe_n_i};
    sclk_d_reg <= sclk_s;
    cs_d_reg <= cs_s;
    // the edge detectors read only the second stages
    preset_d_reg <= preset_s;
  end
end
////////////////////////////////////////////////////////////////////////////////
// serial shifter and frame counter
always @(posedge core_clk_i) begin
  if (rst_i) begin
    shift_reg <= 16'h0000;
    last_word_reg <= 16'h0000;
    readback_reg <= 16'h0000;
    readback_pend_reg <= 1'b0;
    bit_cnt_reg <= 5'h00;
    have_word_reg <= 1'b0;
    sdo_o <= 1'b0;
    sdo_oe_o <= 1'b0;
  end else if (clk_en_i) begin
    // open drain: the pin is pulled low only for a zero bit
    sdo_oe_o <= ~cs_s & ~sdo_o;
    // a frame sent during a store is lost, not queued
    if (!cs_s && sclk_rise && !store_busy_reg) begin
      shift_reg <= {shift_reg[14:0], sdi_sync_reg[1]};
      readback_reg <= {readback_reg[14:0], 1'b0};
      bit_cnt_reg <= (bit_cnt_reg == 5'h0F) ? 5'h10 :
                     {1'b0, bit_cnt_reg[3:0] + 4'h1};
    end
    if (!cs_s && sclk_fall) begin
      // readback replaces the chain output for one word only
      sdo_o <= readback_pend_reg ? readback_reg[15] : shift_reg[15];
    end
    if (cs_rise) begin
      // a cut frame only clears the count
      bit_cnt_reg <= 5'h00;
      if (exec) begin
        last_word_reg <= word;
        have_word_reg <= 1'b1;
        readback_pend_reg <= 1'b0;
        if (cmd == `CMD_READ_STORE) begin
          readback_reg <= {8'h00, nvs_reg[adr]};
          readback_pend_reg <= 1'b1;
        end else if (cmd == `CMD_READ_WIPER) begin
          readback_reg <= {10'h000, wiper_reg[adr[1:0]]};
          readback_pend_reg <= 1'b1;
        end
      end
    end
    if (cs_s && !cs_rise) sdo_o <= readback_pend_reg ? readback_reg[15]
                                                      : shift_reg[15];
  end
end
////////////////////////////////////////////////////////////////////////////////
// store timer and ready pulse
// counted in core cycles; a bench may shorten it by the parameter
always @(posedge core_clk_i) begin
  if (rst_i) begin
    store_cnt_reg <= 32'h00000000;
    store_busy_reg <= 1'b0;
    ready_n_o <= 1'b1;
    ready_oe_o <= 1'b0;
  end else if (clk_en_i) begin
    ready_n_o <= 1'b1;
    ready_oe_o <= 1'b0;
    if (store_busy_reg) begin
      if (store_cnt_reg == STORE_CYCLES - 1) begin
        store_busy_reg <= 1'b0;
        // one core cycle low, then the pin floats high again
        ready_n_o <= 1'b0;
        ready_oe_o <= 1'b1;
      end else begin
        store_cnt_reg <= store_cnt_reg + 32'h00000001;
      end
    end else if (exec && (cmd == `CMD_STORE_WIPER ||
                          cmd == `CMD_STORE_BYTE)) begin
      store_busy_reg <= 1'b1;
      store_cnt_reg <= 32'h00000000;
    end
  end
end
////////////////////////////////////////////////////////////////////////////////
// nonvolatile store; reset stands in for the cell contents
genvar gi;
generate
  for (gi = 0; gi < `NV_DEPTH; gi = gi + 1) begin : g_nv
    always @(posedge core_clk_i) begin
      if (rst_i) begin
        nvs_reg[gi] <= (gi < 4) ? `NV_WIPER_RESET :
                       (gi == 4) ? `NV_LATCH_RESET : 8'h00;
      end else if (clk_en_i && exec && adr == gi) begin
        if (cmd == `CMD_STORE_BYTE) nvs_reg[gi] <= dat;
        else if (cmd == `CMD_STORE_WIPER && gi < 4)
          nvs_reg[gi] <= {2'b00, wiper_reg[gi]};
      end
    end
  end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// wiper registers
generate
  for (gi = 0; gi < 4; gi = gi + 1) begin : g_wiper
    wire sel = (adr[1:0] == gi);
    always @(posedge core_clk_i) begin
      if (rst_i) begin
        wiper_reg[gi] <= `WIPER_MID;
      end else if (clk_en_i) begin
        if (boot_reg) begin
          wiper_reg[gi] <= nvs_reg[gi][5:0];
        end else if (!preset_s) begin
          // preset low outranks commands; a frame executed then is lost
          wiper_reg[gi] <= `WIPER_MID;
        end else if (preset_rise) begin
          wiper_reg[gi] <= nvs_reg[gi][5:0];
        end else if (exec) begin
          case (cmd)
            `CMD_RESTORE_ALL:
              wiper_reg[gi] <= nvs_reg[gi][5:0];
            `CMD_RESTORE_ONE: begin
              if (sel) wiper_reg[gi] <= nvs_reg[gi][5:0];
            end
            `CMD_WRITE_WIPER: begin
              if (sel) wiper_reg[gi] <= dat[5:0];
            end
            // all-channel forms move the four channels in one cycle
            `CMD_SHR_ALL, `CMD_DEC_ALL, `CMD_SHL_ALL, `CMD_INC_ALL:
              wiper_reg[gi] <= wiper_op(cmd, wiper_reg[gi]);
            `CMD_SHR_ONE, `CMD_DEC_ONE, `CMD_SHL_ONE, `CMD_INC_ONE: begin
              // the data byte plays no part here
              if (sel)
                wiper_reg[gi] <= wiper_op(cmd, wiper_reg[gi]);
            end
            default: wiper_reg[gi] <= wiper_reg[gi];
          endcase
        end
      end
    end
  end
endgenerate
////////////////////////////////////////////////////////////////////////////////
// power-on preset, latched outputs, read state, tap decode
integer ti;
always @(posedge core_clk_i) begin
  if (rst_i) begin
    boot_reg <= 1'b1;
    latched_output_one_o <= 1'b1;
    latched_output_two_o <= 1'b1;
    read_state_o <= 1'b0;
    // tap zero of each channel, matching the zero code shown in reset
    tap_select_o <= {4{64'h0000000000000001}};
    wiper_register_o <= 24'h000000;
  end else if (clk_en_i) begin
    boot_reg <= 1'b0;
    // the preset strobe leaves the latched outputs alone
    if (boot_reg || (exec && (cmd == `CMD_RESTORE_ONE ||
                              cmd == `CMD_RESTORE_ALL))) begin
      latched_output_one_o <= nvs_reg[`NV_LATCH_ADR][0];
      latched_output_two_o <= nvs_reg[`NV_LATCH_ADR][1];
    end
    // read state only flags the higher-power mode; nothing else uses it
    if (exec && cmd == `CMD_RESTORE_ONE) read_state_o <= 1'b1;
    else if (exec && cmd == `CMD_NOP) read_state_o <= 1'b0;
    // one 64-bit tap word per channel, channel 0 lowest
    for (ti = 0; ti < 4; ti = ti + 1) begin
      wiper_register_o[ti*6 +: 6] <= wiper_reg[ti];
      tap_select_o[ti*64 +: 64] <= 64'h1 << wiper_reg[ti];
    end
  end
end
endmodule // quad_wiper_command_logic

// file: rtl/quad_wiper_defines.vh
`ifndef QUAD_WIPER_DEFINES_VH
`define QUAD_WIPER_DEFINES_VH
// serial word layout
`define FRAME_BITS 16
`define CMD_MSB 15
`define CMD_LSB 12
`define ADR_MSB 11
`define ADR_LSB 8
`define WIPER_W 6
// command codes
`define CMD_NOP 4'h0
`define CMD_RESTORE_ONE 4'h1
`define CMD_STORE_WIPER 4'h2
`define CMD_STORE_BYTE 4'h3
`define CMD_SHR_ONE 4'h4
`define CMD_SHR_ALL 4'h5
`define CMD_DEC_ONE 4'h6
`define CMD_DEC_ALL 4'h7
`define CMD_RESTORE_ALL 4'h8
`define CMD_READ_STORE 4'h9
`define CMD_READ_WIPER 4'hA
`define CMD_WRITE_WIPER 4'hB
`define CMD_SHL_ONE 4'hC
`define CMD_SHL_ALL 4'hD
`define CMD_INC_ONE 4'hE
`define CMD_INC_ALL 4'hF
// nonvolatile map: 0..3 wipers, 4 latched outputs, 5..15 user bytes
`define NV_DEPTH 16
`define NV_LATCH_ADR 4'h4
`define WIPER_MID 6'h20
`define WIPER_FULL 6'h3F
`define NV_WIPER_RESET 8'h20
`define NV_LATCH_RESET 8'h03
// store time
`define STORE_MS 25
`define CLK_MHZ 125
`define STORE_CYCLES (`STORE_MS * `CLK_MHZ * 1000)
`endif
